// *** line_ctrl_pkg.sv ***
// Package with register map, field positions and codes for the line interface control block.
package line_ctrl_pkg;

	// ----------------------------------------
	// Register map (printed offsets are not word multiples, so they are indices)
	// ----------------------------------------
	localparam logic [7:0] IDX_LINE_CTRL_ONE   = 8'h78;
	localparam logic [7:0] IDX_LINE_CTRL_TWO   = 8'h79;
	localparam logic [7:0] IDX_LINE_CTRL_THREE = 8'h7A;
	localparam logic [7:0] IDX_LINE_CTRL_FOUR  = 8'h7B;
	localparam logic [7:0] IDX_LINE_STATUS     = 8'h7C;
	localparam logic [7:0] RESET_LINE_CTRL     = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_TX_POWERDOWN_N     = 0;
	localparam int POS_JATT_DISABLE       = 1;
	localparam int POS_JATT_DEPTH_SEL     = 2;
	localparam int POS_JATT_PLACE_SEL     = 3;
	localparam int POS_BUILDOUT_LSB       = 5;
	localparam int POS_CUSTOM_DRIVER_SEL  = 0;
	localparam int POS_SHORT_LIMIT_DIS    = 1;
	localparam int POS_JATT_CLK_MUX       = 3;
	localparam int POS_TX_DATA_ENABLE     = 4;
	localparam int POS_INSERT_VIOLATION   = 5;
	localparam int POS_LINE_IF_RESET      = 6;
	localparam int POS_LINE_STANDARD_SEL  = 7;
	localparam int POS_TX_ALT_PATTERN     = 0;
	localparam int POS_TX_SYNC_CLK_EN     = 1;
	localparam int POS_RX_SYNC_CLK_EN     = 2;
	localparam int POS_RX_EDGE_SEL        = 5;
	localparam int POS_TX_EDGE_SEL        = 6;
	localparam int POS_RX_TERM_LSB        = 0;
	localparam int POS_TX_TERM_LSB        = 2;
	localparam int POS_MARK_INV_INVERT    = 6;
	localparam int POS_MARK_INV_ENABLE    = 7;

	// ----------------------------------------
	// Codes and depths
	// ----------------------------------------
	localparam logic [2:0] BUILDOUT_ZERO  = 3'h0;
	localparam logic [7:0] JATT_DEPTH_LONG  = 8'h80;
	localparam logic [7:0] JATT_DEPTH_SHORT = 8'h20;
	localparam logic [3:0] RUN_OF_ONES    = 4'h3;
	localparam logic [7:0] RX_QUARTER     = 8'h0C;

	typedef enum logic [1:0] {
		VIOL_IDLE  = 2'b00,
		VIOL_ARMED = 2'b01,
		VIOL_DONE  = 2'b10
	} viol_state_t;

endpackage : line_ctrl_pkg

// *** edge_sync.sv ***
// Two-stage synchroniser with rising and falling edge pulses.
module edge_sync
	import line_ctrl_pkg::*;
(
	input  wire logic i_clk,   // System clock.
	input  wire logic i_srst,  // Synchronous reset.
	input  wire logic i_async, // Input from another domain.
	output logic      o_level, // Synchronised level.
	output logic      o_rise,  // One-cycle pulse on a rising edge.
	output logic      o_fall   // One-cycle pulse on a falling edge.
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_level = sync_r;
	assign o_rise  = sync_r & ~prev_r;
	assign o_fall  = ~sync_r & prev_r;
endmodule : edge_sync

// *** cmi_encoder.sv ***
// Code mark inversion bit encoder driven by half-bit strobes.
module cmi_encoder
	import line_ctrl_pkg::*;
(
	input  wire logic i_clk,    // System clock.
	input  wire logic i_srst,   // Synchronous reset.
	input  wire logic i_load,   // Start of bit period, with new bit.
	input  wire logic i_half,   // Middle of bit period.
	input  wire logic i_bit,    // Bit to encode.
	output logic      o_line    // Coded line level.
);
	logic mark_lvl_r;
	logic cur_bit_r;
	logic line_r;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mark_lvl_r <= 1'b0;
			cur_bit_r  <= 1'b0;
			line_r     <= 1'b0;
		end else if (i_load) begin
			cur_bit_r <= i_bit;
			if (i_bit) begin
				line_r     <= ~mark_lvl_r;
				mark_lvl_r <= ~mark_lvl_r;
			end else begin
				line_r <= 1'b0;
			end
		end else if (i_half && !cur_bit_r) begin
			line_r <= 1'b1;
		end
	end

	assign o_line = line_r;

	AST_ZERO_RISES: assert property (@(posedge i_clk) disable iff (i_srst)
		i_half && !cur_bit_r && !i_load |=> line_r)
		else $error("zero bit did not rise at mid period");
endmodule : cmi_encoder

// *** line_ctrl_cmi.sv ***
// Line interface control registers with CMI coder, decoder and transmit pattern logic.

// Behaviour
// - CMI one bit is a steady level for the whole bit period.
// - CMI zero bit is low then high, rising at mid period.
// - Mark inversion enable switches both paths to CMI on the positive output.
// - Zero substitution may still be applied ahead of CMI coding.
// - In CMI the positive input is decoded; clock recovered and data aligned.
// - Power-down bit low tri-states both transmit outputs.
// - Jitter attenuator active when disable bit is zero.
// - Depth select gives 128 bits when zero, 32 when one.
// - Placement bit puts attenuator in receive path at zero, transmit at one.
// - Three-bit buildout selects one of eight T1 output settings.
// - Custom driver with zero buildout gives square wave, else open drain.
// - Short limit disable low keeps the current limiter enabled.
// - Clock mux selects master clock at zero, PLL at one.
// - Data enable low sends all ones timed by attenuator clock.
// - Rising violation bit inserts one violation, sent on the third consecutive one.
// - Rising line reset bit resets recovery and recenters attenuator.
// - Standard select zero is T1, one is E1.
// - Alternate pattern bit sends 1010 timed by transmit clock.
// - Sync clock enables put each path into square-wave clock mode.
// - Receive edge select updates outputs on rising or falling recovered edge.
// - Transmit edge select samples inputs on falling or rising clock edge.
// - Receive termination code 00 off, else 75, 100, 120 ohms.
// - Transmit termination code 00 off, else 75, 100, 120 ohms.
// - Invert bit inverts CMI on transmit and receive pins.
module line_ctrl_cmi
	import line_ctrl_pkg::*;
(
	input  wire logic        i_clk,             // System clock, 100 MHz.
	input  wire logic        i_srst,            // Synchronous reset, active high.
	input  wire logic        i_psel,            // APB select.
	input  wire logic        i_penable,         // APB enable.
	input  wire logic        i_pwrite,          // APB write.
	input  wire logic [11:0] i_paddr,           // APB byte address.
	input  wire logic [31:0] i_pwdata,          // APB write data.
	output logic      [31:0] o_prdata,          // APB read data.
	output logic             o_pready,          // APB ready.
	output logic             o_pslverr,         // APB error on unmapped address.
	input  wire logic        i_tx_clock_in,     // Transmit line clock pin.
	input  wire logic        i_tx_pos_data_in,  // Transmit positive data pin.
	input  wire logic        i_tx_neg_data_in,  // Transmit negative data pin.
	input  wire logic        i_jatt_clock,      // Attenuator clock.
	input  wire logic        i_rx_line_pos,     // Receive positive line input.
	output logic             o_tx_line_pos,     // Transmit positive line level.
	output logic             o_tx_line_pos_oe_n,// Positive output enable, low drives.
	output logic             o_tx_line_neg,     // Transmit negative line level.
	output logic             o_tx_line_neg_oe_n,// Negative output enable, low drives.
	output logic             o_rx_clock_out,    // Recovered clock output.
	output logic             o_rx_pos_data_out, // Recovered positive data.
	output logic             o_rx_neg_data_out, // Recovered negative data.
	output logic             o_violation,       // Pulse when a violation is inserted.
	output logic             o_recovery_reset,  // Pulse resetting recovery and attenuator.
	output logic      [7:0]  o_jatt_depth,      // Active attenuator depth in bits, 0 if removed.
	output logic             o_jatt_in_tx,      // Attenuator sits in transmit path.
	output logic             o_jatt_clk_pll,    // Attenuator clock taken from PLL.
	output logic             o_limiter_en,      // Current limiter enabled.
	output logic             o_line_e1,         // E1 operation selected.
	output logic      [2:0]  o_buildout,        // Buildout select.
	output logic             o_square_wave,     // Square wave driver mode.
	output logic             o_open_drain,      // Open-drain driver mode.
	output logic             o_tx_sync_clk,     // Transmit sync clock mode.
	output logic             o_rx_sync_clk,     // Receive sync clock mode.
	output logic      [1:0]  o_rx_term,         // Receive termination code.
	output logic      [1:0]  o_tx_term,         // Transmit termination code.
	output logic             o_cmi_mode         // Mark inversion paths active.
);
	// ----------------------------------------
	// Register bank
	// ----------------------------------------
	logic [7:0] ctrl_one_r;
	logic [7:0] ctrl_two_r;
	logic [7:0] ctrl_three_r;
	logic [7:0] ctrl_four_r;
	logic [9:0] word_idx;
	logic       acc;
	logic       hit;

	assign word_idx = i_paddr[11:2];
	assign acc      = i_psel && i_penable && !o_pready;
	assign hit      = (word_idx[7:0] >= IDX_LINE_CTRL_ONE) && (word_idx[7:0] <= IDX_LINE_STATUS)
		&& (word_idx[9:8] == 2'b00);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_one_r   <= RESET_LINE_CTRL;
			ctrl_two_r   <= RESET_LINE_CTRL;
			ctrl_three_r <= RESET_LINE_CTRL;
			ctrl_four_r  <= RESET_LINE_CTRL;
		end else if (acc && i_pwrite) begin
			if (word_idx == {2'b00, IDX_LINE_CTRL_ONE}) begin
				ctrl_one_r <= i_pwdata[7:0];
			end else if (word_idx == {2'b00, IDX_LINE_CTRL_TWO}) begin
				ctrl_two_r <= i_pwdata[7:0];
			end else if (word_idx == {2'b00, IDX_LINE_CTRL_THREE}) begin
				ctrl_three_r <= i_pwdata[7:0];
			end else if (word_idx == {2'b00, IDX_LINE_CTRL_FOUR}) begin
				ctrl_four_r <= i_pwdata[7:0];
			end
		end
	end

	// The status word reports the live transmit source and violation state.
	logic [7:0] status;
	viol_state_t viol_state_r;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end else begin
			o_pready  <= acc;
			o_pslverr <= acc && !hit;
			if (acc && !i_pwrite) begin
				if (word_idx == {2'b00, IDX_LINE_CTRL_ONE}) begin
					o_prdata <= {24'h000000, ctrl_one_r};
				end else if (word_idx == {2'b00, IDX_LINE_CTRL_TWO}) begin
					o_prdata <= {24'h000000, ctrl_two_r};
				end else if (word_idx == {2'b00, IDX_LINE_CTRL_THREE}) begin
					o_prdata <= {24'h000000, ctrl_three_r};
				end else if (word_idx == {2'b00, IDX_LINE_CTRL_FOUR}) begin
					o_prdata <= {24'h000000, ctrl_four_r};
				end else if (word_idx == {2'b00, IDX_LINE_STATUS}) begin
					o_prdata <= {24'h000000, status};
				end else begin
					o_prdata <= 32'h00000000;
				end
			end
		end
	end

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	logic       tx_powerdown_n, tx_data_enable, insert_violation, line_if_reset;
	logic       tx_alt_pattern, tx_edge_sel, rx_edge_sel, mark_inv_enable, mark_inv_invert;
	logic [2:0] buildout;
	logic       custom_driver_sel;

	assign tx_powerdown_n    = ctrl_one_r[POS_TX_POWERDOWN_N];
	assign buildout          = ctrl_one_r[POS_BUILDOUT_LSB +: 3];
	assign custom_driver_sel = ctrl_two_r[POS_CUSTOM_DRIVER_SEL];
	assign tx_data_enable    = ctrl_two_r[POS_TX_DATA_ENABLE];
	assign insert_violation  = ctrl_two_r[POS_INSERT_VIOLATION];
	assign line_if_reset     = ctrl_two_r[POS_LINE_IF_RESET];
	assign tx_alt_pattern    = ctrl_three_r[POS_TX_ALT_PATTERN];
	assign rx_edge_sel       = ctrl_three_r[POS_RX_EDGE_SEL];
	assign tx_edge_sel       = ctrl_three_r[POS_TX_EDGE_SEL];
	assign mark_inv_invert   = ctrl_four_r[POS_MARK_INV_INVERT];
	assign mark_inv_enable   = ctrl_four_r[POS_MARK_INV_ENABLE];

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_jatt_depth   <= 8'h00;
			o_jatt_in_tx   <= 1'b0;
			o_jatt_clk_pll <= 1'b0;
			o_limiter_en   <= 1'b0;
			o_line_e1      <= 1'b0;
			o_buildout     <= 3'h0;
			o_square_wave  <= 1'b0;
			o_open_drain   <= 1'b0;
			o_tx_sync_clk  <= 1'b0;
			o_rx_sync_clk  <= 1'b0;
			o_rx_term      <= 2'h0;
			o_tx_term      <= 2'h0;
			o_cmi_mode     <= 1'b0;
		end else begin
			o_jatt_depth   <= ctrl_one_r[POS_JATT_DISABLE] ? 8'h00 :
				(ctrl_one_r[POS_JATT_DEPTH_SEL] ? JATT_DEPTH_SHORT : JATT_DEPTH_LONG);
			o_jatt_in_tx   <= ctrl_one_r[POS_JATT_PLACE_SEL];
			o_jatt_clk_pll <= ctrl_two_r[POS_JATT_CLK_MUX];
			o_limiter_en   <= !ctrl_two_r[POS_SHORT_LIMIT_DIS];
			o_line_e1      <= ctrl_two_r[POS_LINE_STANDARD_SEL];
			o_buildout     <= buildout;
			o_square_wave  <= custom_driver_sel && (buildout == BUILDOUT_ZERO);
			o_open_drain   <= custom_driver_sel && (buildout != BUILDOUT_ZERO);
			o_tx_sync_clk  <= ctrl_three_r[POS_TX_SYNC_CLK_EN];
			o_rx_sync_clk  <= ctrl_three_r[POS_RX_SYNC_CLK_EN];
			o_rx_term      <= ctrl_four_r[POS_RX_TERM_LSB +: 2];
			o_tx_term      <= ctrl_four_r[POS_TX_TERM_LSB +: 2];
			o_cmi_mode     <= mark_inv_enable;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic tclk_rise, tclk_fall, jclk_rise, rx_lvl, rx_rise, tpos_lvl, tneg_lvl;

	edge_sync u_sync_tclk (.i_clk(i_clk), .i_srst(i_srst), .i_async(i_tx_clock_in),
		.o_level(), .o_rise(tclk_rise), .o_fall(tclk_fall));
	edge_sync u_sync_jclk (.i_clk(i_clk), .i_srst(i_srst), .i_async(i_jatt_clock),
		.o_level(), .o_rise(jclk_rise), .o_fall());
	edge_sync u_sync_rx   (.i_clk(i_clk), .i_srst(i_srst), .i_async(i_rx_line_pos ^ mark_inv_invert),
		.o_level(rx_lvl), .o_rise(rx_rise), .o_fall());
	edge_sync u_sync_tpos (.i_clk(i_clk), .i_srst(i_srst), .i_async(i_tx_pos_data_in),
		.o_level(tpos_lvl), .o_rise(), .o_fall());
	edge_sync u_sync_tneg (.i_clk(i_clk), .i_srst(i_srst), .i_async(i_tx_neg_data_in),
		.o_level(tneg_lvl), .o_rise(), .o_fall());

	// ----------------------------------------
	// Transmit bit source
	// ----------------------------------------
	// All-ones is paced by the attenuator clock, the test pattern and data by the transmit clock.
	logic tx_sample, bit_strobe, half_strobe, tx_bit, alt_r, src_bit;
	logic [3:0] ones_run_r;
	logic viol_now;

	assign tx_sample   = tx_edge_sel ? tclk_rise : tclk_fall;
	assign bit_strobe  = tx_data_enable ? tx_sample : jclk_rise;
	assign half_strobe = tx_data_enable ? (tx_edge_sel ? tclk_fall : tclk_rise) : 1'b0;
	// Incoming pos/neg rails are already zero-substituted upstream, so either rail marks a one.
	assign src_bit     = tpos_lvl | tneg_lvl;
	assign tx_bit      = !tx_data_enable ? 1'b1 : (tx_alt_pattern ? alt_r : src_bit);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			alt_r <= 1'b0;
		end else if (bit_strobe && tx_alt_pattern) begin
			alt_r <= ~alt_r;
		end
	end

	// ----------------------------------------
	// Violation insertion
	// ----------------------------------------
	logic viol_req_prev_r;

	assign viol_now = (viol_state_r == VIOL_ARMED) && bit_strobe && tx_bit && (ones_run_r >= RUN_OF_ONES - 4'h1);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ones_run_r <= 4'h0;
		end else if (bit_strobe) begin
			ones_run_r <= tx_bit ? ((ones_run_r == 4'hF) ? ones_run_r : ones_run_r + 4'h1) : 4'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			viol_req_prev_r <= 1'b0;
			viol_state_r    <= VIOL_IDLE;
			o_violation     <= 1'b0;
		end else begin
			viol_req_prev_r <= insert_violation;
			o_violation     <= viol_now;
			case (viol_state_r)
				VIOL_IDLE: if (insert_violation && !viol_req_prev_r) viol_state_r <= VIOL_ARMED;
				VIOL_ARMED: if (viol_now) viol_state_r <= VIOL_DONE;
				VIOL_DONE: if (!insert_violation) viol_state_r <= VIOL_IDLE;
				default: viol_state_r <= VIOL_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Line drive
	// ----------------------------------------
	logic cmi_line, ami_mark_r, pos_r, neg_r;

	cmi_encoder u_enc (.i_clk(i_clk), .i_srst(i_srst), .i_load(bit_strobe), .i_half(half_strobe),
		.i_bit(tx_bit), .o_line(cmi_line));

	// Bipolar marks alternate; a violation repeats the last polarity.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ami_mark_r <= 1'b0;
			pos_r      <= 1'b0;
			neg_r      <= 1'b0;
		end else if (bit_strobe) begin
			pos_r <= tx_bit && (viol_now ? ami_mark_r : !ami_mark_r);
			neg_r <= tx_bit && (viol_now ? !ami_mark_r : ami_mark_r);
			if (tx_bit && !viol_now) ami_mark_r <= !ami_mark_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_tx_line_pos      <= 1'b0;
			o_tx_line_neg      <= 1'b0;
			o_tx_line_pos_oe_n <= 1'b1;
			o_tx_line_neg_oe_n <= 1'b1;
		end else begin
			o_tx_line_pos      <= mark_inv_enable ? (cmi_line ^ mark_inv_invert) : pos_r;
			o_tx_line_neg      <= mark_inv_enable ? 1'b0 : neg_r;
			// Open drain releases the pin in the cycle after the registered level is high.
			o_tx_line_pos_oe_n <= !tx_powerdown_n || (o_open_drain && o_tx_line_pos);
			o_tx_line_neg_oe_n <= !tx_powerdown_n || (o_open_drain && o_tx_line_neg);
		end
	end

	// ----------------------------------------
	// Receive CMI decode and clock recovery
	// ----------------------------------------
	// Zeros give a mid-bit rising edge; the recovered clock falls a quarter bit after each.
	logic [7:0] rx_cnt_r;
	logic       lir_prev_r, rx_clk_r, rx_data_r, rx_clk_prev_r, rx_upd;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			lir_prev_r       <= 1'b0;
			o_recovery_reset <= 1'b0;
		end else begin
			lir_prev_r       <= line_if_reset;
			o_recovery_reset <= line_if_reset && !lir_prev_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_recovery_reset) begin
			rx_cnt_r  <= 8'h00;
			rx_clk_r  <= 1'b0;
			rx_data_r <= 1'b0;
		end else if (mark_inv_enable) begin
			if (rx_rise) begin
				rx_cnt_r  <= 8'h00;
				rx_clk_r  <= 1'b1;
				rx_data_r <= 1'b0;
			end else begin
				rx_cnt_r <= (rx_cnt_r == 8'hFF) ? rx_cnt_r : rx_cnt_r + 8'h01;
				if (rx_cnt_r == RX_QUARTER) begin
					rx_clk_r <= 1'b0;
				end else if (rx_cnt_r == RX_QUARTER + RX_QUARTER + RX_QUARTER) begin
					rx_clk_r  <= 1'b1;
					rx_data_r <= 1'b1;
					rx_cnt_r  <= RX_QUARTER - RX_QUARTER;
				end
			end
		end else begin
			rx_clk_r  <= rx_lvl;
			rx_data_r <= rx_lvl;
		end
	end

	assign rx_upd = rx_edge_sel ? (rx_clk_prev_r && !rx_clk_r) : (!rx_clk_prev_r && rx_clk_r);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rx_clk_prev_r     <= 1'b0;
			o_rx_clock_out    <= 1'b0;
			o_rx_pos_data_out <= 1'b0;
			o_rx_neg_data_out <= 1'b0;
		end else begin
			rx_clk_prev_r  <= rx_clk_r;
			o_rx_clock_out <= rx_clk_r;
			if (rx_upd) begin
				o_rx_pos_data_out <= rx_data_r;
				o_rx_neg_data_out <= 1'b0;
			end
		end
	end

	assign status = {4'h0, mark_inv_enable, viol_state_r == VIOL_ARMED, tx_alt_pattern, tx_data_enable};

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_POWERDOWN_TRISTATE: assert property (@(posedge i_clk) disable iff (i_srst)
		!tx_powerdown_n |=> o_tx_line_pos_oe_n && o_tx_line_neg_oe_n)
		else $error("outputs driven while powered down");
	AST_DEPTH_SELECT: assert property (@(posedge i_clk) disable iff (i_srst)
		!ctrl_one_r[POS_JATT_DISABLE] && ctrl_one_r[POS_JATT_DEPTH_SEL] |=> o_jatt_depth == 8'h20)
		else $error("attenuator depth wrong");
	AST_JATT_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
		ctrl_one_r[POS_JATT_DISABLE] |=> o_jatt_depth == 8'h00)
		else $error("attenuator still active");
	AST_ALL_ONES: assert property (@(posedge i_clk) disable iff (i_srst)
		!tx_data_enable && bit_strobe |=> pos_r != neg_r)
		else $error("all ones not sent");
	AST_ONE_VIOLATION: assert property (@(posedge i_clk) disable iff (i_srst)
		viol_now |=> viol_state_r == VIOL_DONE ##1 !viol_now)
		else $error("violation repeated");
	AST_RESET_PULSE: assert property (@(posedge i_clk) disable iff (i_srst)
		$rose(line_if_reset) |=> o_recovery_reset ##1 !o_recovery_reset)
		else $error("line reset pulse wrong");
	AST_SQUARE_OPEN: assert property (@(posedge i_clk) disable iff (i_srst)
		custom_driver_sel && buildout != 3'h0 |=> o_open_drain && !o_square_wave)
		else $error("driver mode wrong");
	AST_CMI_NEG_IDLE: assert property (@(posedge i_clk) disable iff (i_srst)
		mark_inv_enable |=> !o_tx_line_neg)
		else $error("negative line active in CMI");
	AST_LIMITER: assert property (@(posedge i_clk) disable iff (i_srst)
		!ctrl_two_r[POS_SHORT_LIMIT_DIS] |=> o_limiter_en)
		else $error("limiter not enabled");
	COV_VIOLATION: cover property (@(posedge i_clk) viol_now);
	COV_CMI_TX: cover property (@(posedge i_clk) mark_inv_enable && bit_strobe && tx_data_enable);
	COV_RX_CLK: cover property (@(posedge i_clk) mark_inv_enable && rx_upd);
	COV_ALT: cover property (@(posedge i_clk) tx_alt_pattern && bit_strobe);
endmodule : line_ctrl_cmi

// *** line_partner.sv ***
// Far-side optical module model: link clock, transmit data and a receive loopback.
module line_partner (
	input  wire logic i_run,     // Run the link clock.
	input  wire logic i_bit,     // Data bit to send.
	input  wire logic i_line,    // Coded line from the block.
	output logic      o_clk,     // Transmit line clock.
	output logic      o_data,    // Transmit data.
	output logic      o_rx_line  // Optical return path.
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_clk = 1'b0;
	initial o_data = 1'b0;
	// The clock stands still while i_run is low, so no transmit clock edges reach the block.
	always #62.5 if (i_run) o_clk = ~o_clk;
	always @(posedge o_clk) o_data <= i_bit;
	assign o_rx_line = i_line;
endmodule : line_partner

// *** line_ctrl_cmi_test.sv ***
// Self-checking testbench for the line interface control block.
module line_ctrl_cmi_test;
	import line_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, run = 1'b0, bit_in = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0, rnd = 32'h6DC5168B, prdata;
	logic        tclk, tdat, rxl, txp, txpo, txno, rrst, jin, jpll, lim, e1, pready, pslverr;
	logic [7:0]  jdep;
	logic [2:0]  bo;
	logic [1:0]  txt, rxt;
	logic        jclk = 1'b0, txn, rxn, viol, tsc, rsc, sq, od, cmi;
	logic [32:0] expq[$];
	int          failures = 0, check_count = 0, rises = 0, resets = 0, viols = 0, e;
	always #5 i_clk = ~i_clk;
	// Attenuator clock runs slower than the link clock, so all-ones pacing is told apart from data pacing.
	always #100 jclk = ~jclk;
	line_partner FAR (.i_run(run), .i_bit(bit_in), .i_line(txp), .o_clk(tclk), .o_data(tdat), .o_rx_line(rxl));
	line_ctrl_cmi DUT (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_tx_clock_in(tclk), .i_tx_pos_data_in(tdat), .i_tx_neg_data_in(1'b0),
		.i_jatt_clock(jclk), .i_rx_line_pos(rxl), .o_tx_line_pos(txp), .o_tx_line_pos_oe_n(txpo),
		.o_tx_line_neg(txn), .o_tx_line_neg_oe_n(txno), .o_rx_clock_out(), .o_rx_pos_data_out(),
		.o_rx_neg_data_out(rxn), .o_violation(viol),
		.o_recovery_reset(rrst), .o_jatt_depth(jdep), .o_jatt_in_tx(jin), .o_jatt_clk_pll(jpll), .o_limiter_en(lim),
		.o_line_e1(e1), .o_buildout(bo), .o_square_wave(sq), .o_open_drain(od), .o_tx_sync_clk(tsc),
		.o_rx_sync_clk(rsc), .o_rx_term(rxt), .o_tx_term(txt), .o_cmi_mode(cmi));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic check(input string what, input logic [32:0] exp, got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task summarize;
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic apb(input logic wr, input logic [7:0] idx, d, input logic [32:0] exp);
		int n;
		n = 0;
		expq.push_back(exp);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= {2'h0, idx, 2'h0};
		i_pwdata <= {24'h0, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			failures++;
			summarize();
		end
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask : apb
	// Each answered transfer is matched against the oldest expectation.
	always @(posedge i_clk) begin
		if (i_psel && i_penable && pready === 1'b1)
			check("apb", expq.pop_front(), {pslverr, i_pwrite ? 32'h0 : prdata});
		if (rrst === 1'b1)
			resets++;
		if (viol === 1'b1)
			viols++;
		if ($rose(txp))
			rises++;
	end
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		repeat (6) @(posedge i_clk);
		i_srst <= 1'b0;
		for (int k = 0; k < 20; k++) begin
			rnd = xs(rnd);
			if (k < 4)
				apb(1'b0, 8'(IDX_LINE_CTRL_ONE + k), 8'h00, 33'h0);
			apb(1'b1, 8'(IDX_LINE_CTRL_ONE + k % 4), rnd[7:0], 33'h0);
			apb(1'b0, 8'(IDX_LINE_CTRL_ONE + k % 4), 8'h00, {25'h0, rnd[7:0]});
		end
		apb(1'b1, 8'h40, 8'hFF, 33'h1_0000_0000);
		apb(1'b0, 8'h40, 8'h00, 33'h1_0000_0000);
		// Clear termination and mark inversion before the attenuator and buildout sweep below.
		apb(1'b1, IDX_LINE_CTRL_FOUR, 8'h00, 33'h0);
		for (int j = 0; j < 8; j++) begin
			apb(1'b1, IDX_LINE_CTRL_ONE, 8'(j * 2 + 8'hA1), 33'h0);
			@(posedge i_clk);
			check("depth", j[0] ? 8'h00 : (j[1] ? JATT_DEPTH_SHORT : JATT_DEPTH_LONG), jdep);
			check("place", j[2], jin);
			check("buildout", 3'h5, bo);
		end
		apb(1'b1, IDX_LINE_CTRL_ONE, 8'h00, 33'h0);
		@(posedge i_clk);
		check("powerdown", 2'b11, {txpo, txno});
		apb(1'b1, IDX_LINE_CTRL_TWO, 8'h8B, 33'h0);
		resets = 0;
		for (int j = 0; j < 4; j++)
			apb(1'b1, IDX_LINE_CTRL_TWO, j == 2 ? 8'h8B : 8'hCB, 33'h0);
		repeat (3) @(posedge i_clk);
		check("reset_pulses", 2, resets);
		check("mode", 3'b110, {e1, jpll, lim});
		apb(1'b1, IDX_LINE_CTRL_THREE, 8'h06, 33'h0);
		apb(1'b1, IDX_LINE_CTRL_FOUR, 8'h0E, 33'h0);
		@(posedge i_clk);
		check("sync_clk", 2'b11, {tsc, rsc});
		check("terms", 4'hE, {txt, rxt});
		check("driver", 3'b100, {sq, od, cmi});
		apb(1'b1, IDX_LINE_CTRL_FOUR, 8'h80, 33'h0);
		apb(1'b1, IDX_LINE_CTRL_ONE, 8'h01, 33'h0);
		run <= 1'b1;
		// All ones by attenuator clock, zeros, ones, zeros on the rising edge, then the alternating pattern.
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, IDX_LINE_CTRL_TWO, m ? 8'h10 : 8'h00, 33'h0);
			apb(1'b1, IDX_LINE_CTRL_THREE, m == 3 ? 8'h40 : (m == 4 ? 8'h01 : 8'h06), 33'h0);
			bit_in <= (m == 2);
			repeat (40) @(posedge i_clk);
			rises = 0;
			repeat (400) @(posedge i_clk);
			e = (m == 0) ? 10 : ((m == 2 || m == 4) ? 16 : 32);
			check("cmi_rises", 1'b1, rises + 3 >= e && rises <= e + 3);
			check("cmi_lines", 3'b100, {cmi, txn, rxn});
		end
		bit_in <= 1'b1;
		apb(1'b1, IDX_LINE_CTRL_THREE, 8'h06, 33'h0);
		apb(1'b1, IDX_LINE_CTRL_FOUR, 8'h00, 33'h0);
		viols = 0;
		// A second set without a clear must not insert again.
		for (int v = 0; v < 3; v++) begin
			if (v == 2)
				apb(1'b1, IDX_LINE_CTRL_TWO, 8'h10, 33'h0);
			apb(1'b1, IDX_LINE_CTRL_TWO, 8'h30, 33'h0);
			repeat (400) @(posedge i_clk);
			check("violations", v ? v : 1, viols);
		end
		summarize();
	end
endmodule : line_ctrl_cmi_test
